// ==== common/fdc_pkg.sv ====
// Constants, register map and types of the fractional divider oscillator control block
package fdc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_DIV   = 5;
  localparam int NUM_W     = 44;
  localparam int DEN_W     = 32;
  localparam int STEP_W    = 44;
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int NUM_BYTES = 6;
  localparam int DEN_BYTES = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_BASE_ADDR   = 16'h0302;
  localparam logic [15:0] DIV_STRIDE      = 16'h000B;
  localparam logic [3:0]  OFS_NUM         = 4'h0;
  localparam logic [3:0]  OFS_DEN         = 4'h6;
  localparam logic [3:0]  OFS_UPDATE      = 4'hA;
  localparam logic [3:0]  DIV_SPAN        = 4'hB;
  localparam logic [15:0] UPDATE_ALL_ADDR = 16'h0338;
  localparam int          UPDATE_BIT      = 0;
  localparam int          UPDATE_ALL_BIT  = 1;
  localparam logic [15:0] SOFT_RST_ADDR   = 16'h001C;
  localparam int          SOFT_RST_BIT    = 0;
  localparam logic [15:0] BYPASS_ADDR     = 16'h0A04;
  localparam logic [15:0] STEP_REQ_ADDR   = 16'h001D;
  localparam int          INC_BIT         = 0;
  localparam int          DEC_BIT         = 1;
  localparam logic [15:0] STEP_SEL_ADDR   = 16'h001E;
  localparam logic [15:0] STEP_BASE_ADDR  = 16'h0340;
  localparam logic [15:0] STEP_STRIDE     = 16'h0008;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]       BYPASS_RST   = 5'h1F;
  localparam logic [4:0]       STEP_SEL_RST = 5'h00;
  localparam logic [NUM_W-1:0] NUM_RST      = 44'h00500000000;
  localparam logic [DEN_W-1:0] DEN_RST      = 32'h80000000;
  localparam logic [STEP_W-1:0] STEP_RST    = 44'h00000000000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 20;
  localparam int PIN_PULSE_MIN_NS = 100;
  localparam int PIN_PULSE_CYC    = (PIN_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_RST_NS      = 1000;
  localparam int SOFT_RST_CYC     = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FDC_SR_IDLE    = 2'b00,
    FDC_SR_HOLD    = 2'b01,
    FDC_SR_RELEASE = 2'b11
  } fdc_srst_state_t;

endpackage : fdc_pkg

// ==== src/fdc_step_pin.sv ====
// Step request pin conditioner: synchroniser and minimum pulse width qualifier
`timescale 1ns/1ns
`default_nettype none
module fdc_step_pin
  import fdc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // Pin and qualified event
  input  wire logic pin_in,
  output logic      step_out
);

  logic [2:0] sync_r;
  logic       level_r;
  logic [3:0] cnt_r;
  logic       fired_r;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // A change counts only when stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Width qualifier: one event per pulse, short glitches dropped
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_r   <= 4'h0;
      fired_r <= 1'b0;
    end else if (!level_r) begin
      cnt_r   <= 4'h0;
      fired_r <= 1'b0;
    end else if (cnt_r < 4'(PIN_PULSE_CYC)) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      fired_r <= 1'b1;
    end
  end

  assign step_out = level_r && (cnt_r == 4'(PIN_PULSE_CYC)) && !fired_r;

endmodule : fdc_step_pin
`default_nettype wire

// ==== src/fdc_soft_reset.sv ====
// Soft reset sequencer: holds all output clocks off for a fixed time
`timescale 1ns/1ns
`default_nettype none
module fdc_soft_reset
  import fdc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out,
  output logic      clk_enable_out
);

  fdc_srst_state_t state_r;
  fdc_srst_state_t state_nxt;
  logic [7:0]      cnt_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FDC_SR_IDLE: begin
        if (start_in) state_nxt = FDC_SR_HOLD;
      end
      FDC_SR_HOLD: begin
        if (cnt_r == 8'(SOFT_RST_CYC - 1)) state_nxt = FDC_SR_RELEASE;
      end
      FDC_SR_RELEASE: begin
        state_nxt = FDC_SR_IDLE;
      end
      default: begin
        state_nxt = FDC_SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= FDC_SR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= 8'h00;
    end else if (state_r == FDC_SR_HOLD) begin
      cnt_r <= cnt_r + 8'h01;
    end else begin
      cnt_r <= 8'h00;
    end
  end

  // A second request while busy is absorbed by the running sequence
  assign busy_out       = (state_r != FDC_SR_IDLE);
  assign done_out       = (state_r == FDC_SR_RELEASE);
  assign clk_enable_out = !busy_out;

endmodule : fdc_soft_reset
`default_nettype wire

// ==== src/fdc_dco_ctrl.sv ====
// Fractional divider oscillator control: register file, staging and stepping of five dividers
//
// Function
// - Each divider ratio is a 44-bit numerator over a 32-bit denominator register.
// - Writing one divider never disturbs the ratio of any other divider.
// - Numerator changes reach the divider as one clean ratio switch.
// - Denominator change realigns phase only when its top bit changes.
// - Retuning behaves the same in locked, holdover and free-run states.
// - Five-bit bypass mask, bit i for divider i, zero means fractional.
// - Soft reset disables all output clocks until it completes.
// - Output frequency is vco times denominator over numerator times R.
// - A numerator step shifts all outputs of that divider by equal fraction.
// - Increment or decrement request changes selected numerator by its step word.
// - Numerator registers accept direct host writes at any time.
// - A host-written numerator takes effect only when its update bit or the update-all bit is written.
// - Increment and decrement register bits clear themselves.
`timescale 1ns/1ns
`default_nettype none
module fdc_dco_ctrl
  import fdc_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  // Register port (byte wide)
  input  wire logic [ADDR_W-1:0]        reg_addr_in,
  input  wire logic [DATA_W-1:0]        reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [DATA_W-1:0]        reg_rdata_out,
  output logic                          reg_rvalid_out,
  // Step request pins
  input  wire logic                     freq_increment_request_in,
  input  wire logic                     freq_decrement_request_in,
  // Divider ratio outputs
  output logic      [NUM_DIV*NUM_W-1:0] div_num_out,
  output logic      [NUM_DIV*DEN_W-1:0] div_den_out,
  output logic      [NUM_DIV-1:0]       div_load_out,
  output logic      [NUM_DIV-1:0]       div_phase_realign_out,
  output logic      [NUM_DIV-1:0]       div_frac_mode_out,
  // Output clock control
  output logic                          out_clk_enable_out,
  output logic                          soft_reset_busy_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [47:0]       stage_num_r [NUM_DIV];
  logic [DEN_W-1:0]  stage_den_r [NUM_DIV];
  logic [NUM_W-1:0]  act_num_r   [NUM_DIV];
  logic [DEN_W-1:0]  act_den_r   [NUM_DIV];
  logic [47:0]       step_word_r [NUM_DIV];
  logic [NUM_DIV-1:0] load_r;
  logic [NUM_DIV-1:0] realign_r;
  logic [4:0]        bypass_r;
  logic [4:0]        applied_bypass_r;
  logic [4:0]        step_sel_r;
  logic [DATA_W-1:0] rdata_r;
  logic              rvalid_r;

  logic [NUM_DIV-1:0] div_hit;
  logic [NUM_DIV-1:0] step_hit;
  logic [DATA_W-1:0]  div_rbyte  [NUM_DIV];
  logic [DATA_W-1:0]  step_rbyte [NUM_DIV];
  logic [NUM_DIV-1:0] upd;
  logic [NUM_DIV-1:0] step_go;
  logic               update_all;
  logic               inc_reg;
  logic               dec_reg;
  logic               inc_pin;
  logic               dec_pin;
  logic               inc_evt;
  logic               dec_evt;
  logic               srst_start;
  logic               srst_done;
  logic               srst_busy;
  logic               clk_en;
  logic [DATA_W-1:0]  rdata_nxt;

  // ----------------------------------------------------------------
  // Step requests from pins and self-clearing register bits
  // ----------------------------------------------------------------
  fdc_step_pin u_inc_pin (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (freq_increment_request_in),
    .step_out   (inc_pin)
  );

  fdc_step_pin u_dec_pin (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (freq_decrement_request_in),
    .step_out   (dec_pin)
  );

  // Register bits are pulses only and always read back zero
  assign inc_reg = reg_wr_in && (reg_addr_in == STEP_REQ_ADDR) && reg_wdata_in[INC_BIT];
  assign dec_reg = reg_wr_in && (reg_addr_in == STEP_REQ_ADDR) && reg_wdata_in[DEC_BIT];
  assign inc_evt = inc_pin || inc_reg;
  assign dec_evt = dec_pin || dec_reg;

  assign update_all = reg_wr_in && (reg_addr_in == UPDATE_ALL_ADDR) && reg_wdata_in[UPDATE_ALL_BIT];

  // ----------------------------------------------------------------
  // Soft reset
  // ----------------------------------------------------------------
  assign srst_start = reg_wr_in && (reg_addr_in == SOFT_RST_ADDR) && reg_wdata_in[SOFT_RST_BIT];

  fdc_soft_reset u_srst (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .start_in       (srst_start),
    .busy_out       (srst_busy),
    .done_out       (srst_done),
    .clk_enable_out (clk_en)
  );

  // ----------------------------------------------------------------
  // Mode mask
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      bypass_r <= BYPASS_RST;
    end else if (reg_wr_in && (reg_addr_in == BYPASS_ADDR)) begin
      bypass_r <= reg_wdata_in[4:0];
    end
  end

  // Going integer is safe at once; going fractional waits for a soft
  // reset, since the interpolator must restart from a clean state.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      applied_bypass_r <= BYPASS_RST;
    end else if (srst_done) begin
      applied_bypass_r <= bypass_r;
    end else begin
      applied_bypass_r <= applied_bypass_r | bypass_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      step_sel_r <= STEP_SEL_RST;
    end else if (reg_wr_in && (reg_addr_in == STEP_SEL_ADDR)) begin
      step_sel_r <= reg_wdata_in[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Per divider channel
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
    localparam logic [15:0] BASE  = 16'(DIV_BASE_ADDR + DIV_STRIDE * i);
    localparam logic [15:0] SBASE = 16'(STEP_BASE_ADDR + STEP_STRIDE * i);

    logic [15:0]      rel;
    logic [15:0]      srel;
    logic [3:0]       ofs;
    logic [1:0]       dofs;
    logic [NUM_W-1:0] num_nxt;

    assign rel  = reg_addr_in - BASE;
    assign srel = reg_addr_in - SBASE;
    assign ofs  = rel[3:0];
    assign dofs = 2'(ofs - OFS_DEN);

    // Decode is local to the channel so no write ever reaches a neighbour
    assign div_hit[i]  = (reg_addr_in >= BASE) && (rel < {12'h000, DIV_SPAN});
    assign step_hit[i] = (reg_addr_in >= SBASE) && (srel < 16'(NUM_BYTES));

    assign upd[i] = (reg_wr_in && div_hit[i] && (ofs == OFS_UPDATE) && reg_wdata_in[UPDATE_BIT])
                    || update_all;
    assign step_go[i] = step_sel_r[i] && (inc_evt ^ dec_evt);

    // Raising the numerator lowers the output frequency
    assign num_nxt = inc_evt ? act_num_r[i] - step_word_r[i][NUM_W-1:0]
                             : act_num_r[i] + step_word_r[i][NUM_W-1:0];

    // Staged numerator: host bytes take priority over a step copy
    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        stage_num_r[i] <= {4'h0, NUM_RST};
      end else if (reg_wr_in && div_hit[i] && (ofs < OFS_DEN)) begin
        stage_num_r[i][{ofs[2:0], 3'b000} +: 8] <= (ofs == 4'h5) ? {4'h0, reg_wdata_in[3:0]}
                                                                 : reg_wdata_in;
      end else if (step_go[i]) begin
        stage_num_r[i] <= {4'h0, num_nxt};
      end
    end

    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        stage_den_r[i] <= DEN_RST;
      end else if (reg_wr_in && div_hit[i] && (ofs >= OFS_DEN) && (ofs < OFS_UPDATE)) begin
        stage_den_r[i][{dofs, 3'b000} +: 8] <= reg_wdata_in;
      end
    end

    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        step_word_r[i] <= {4'h0, STEP_RST};
      end else if (reg_wr_in && step_hit[i]) begin
        step_word_r[i][{srel[2:0], 3'b000} +: 8] <= (srel[2:0] == 3'h5) ? {4'h0, reg_wdata_in[3:0]}
                                                                          : reg_wdata_in;
      end
    end

    // Active ratio: no dependence on lock, holdover or free-run state
    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        act_num_r[i] <= NUM_RST;
        act_den_r[i] <= DEN_RST;
      end else if (upd[i]) begin
        act_num_r[i] <= stage_num_r[i][NUM_W-1:0];
        act_den_r[i] <= stage_den_r[i];
      end else if (step_go[i]) begin
        act_num_r[i] <= num_nxt;
      end
    end

    // Phase realignment is only requested when the denominator top bit moves
    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        load_r[i]    <= 1'b0;
        realign_r[i] <= 1'b0;
      end else begin
        load_r[i]    <= upd[i] || step_go[i];
        realign_r[i] <= upd[i] && (stage_den_r[i][DEN_W-1] != act_den_r[i][DEN_W-1]);
      end
    end

    // Read-back shows the staged words
    always_comb begin
      div_rbyte[i] = 8'h00;
      if (ofs < OFS_DEN) begin
        div_rbyte[i] = stage_num_r[i][{ofs[2:0], 3'b000} +: 8];
      end else if (ofs < OFS_UPDATE) begin
        div_rbyte[i] = stage_den_r[i][{dofs, 3'b000} +: 8];
      end
    end

    assign step_rbyte[i] = step_word_r[i][{srel[2:0], 3'b000} +: 8];

    assign div_num_out[i*NUM_W +: NUM_W] = act_num_r[i];
    assign div_den_out[i*DEN_W +: DEN_W] = act_den_r[i];
  end

  // ----------------------------------------------------------------
  // Read path: one cycle latency, unmapped bytes read zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    for (int k = 0; k < NUM_DIV; k++) begin
      if (div_hit[k]) rdata_nxt = div_rbyte[k];
      if (step_hit[k]) rdata_nxt = step_rbyte[k];
    end
    if (reg_addr_in == BYPASS_ADDR) rdata_nxt = {3'h0, bypass_r};
    if (reg_addr_in == STEP_SEL_ADDR) rdata_nxt = {3'h0, step_sel_r};
    if (reg_addr_in == SOFT_RST_ADDR) rdata_nxt = {7'h00, srst_busy};
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out         = rdata_r;
  assign reg_rvalid_out        = rvalid_r;
  assign div_load_out          = load_r;
  assign div_phase_realign_out = realign_r;
  assign div_frac_mode_out     = ~applied_bypass_r;
  assign out_clk_enable_out    = clk_en;
  assign soft_reset_busy_out   = srst_busy;

endmodule : fdc_dco_ctrl
`default_nettype wire

// ==== verif/fdc_dco_ctrl_chk.sv ====
// Port-level checks of the fractional divider control block
`timescale 1ns/1ns
`default_nettype none
module fdc_dco_ctrl_chk
  import fdc_pkg::*;
(
  // Clock and reset
  input wire logic                     sys_clk_in,
  input wire logic                     rst_n_in,
  // Register port and pins
  input wire logic [ADDR_W-1:0]        reg_addr_in,
  input wire logic [DATA_W-1:0]        reg_wdata_in,
  input wire logic                     reg_wr_in,
  input wire logic                     reg_rd_in,
  input wire logic [DATA_W-1:0]        reg_rdata_out,
  input wire logic                     freq_increment_request_in,
  input wire logic                     freq_decrement_request_in,
  // Divider and clock outputs
  input wire logic [NUM_DIV*NUM_W-1:0] div_num_out,
  input wire logic [NUM_DIV*DEN_W-1:0] div_den_out,
  input wire logic [NUM_DIV-1:0]       div_load_out,
  input wire logic [NUM_DIV-1:0]       div_phase_realign_out,
  input wire logic [NUM_DIV-1:0]       div_frac_mode_out,
  input wire logic                     out_clk_enable_out,
  input wire logic                     soft_reset_busy_out
);
  // Pin events land about nine cycles late, so updates count only after a quiet spell
  logic [3:0]         quiet_r;
  logic [NUM_DIV-1:0] den_msb;
  logic               upd0;
  logic               srst_wr;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || freq_increment_request_in || freq_decrement_request_in) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  for (genvar i = 0; i < NUM_DIV; i++) begin : g_msb
    assign den_msb[i] = div_den_out[DEN_W*i+DEN_W-1];
  end

  assign upd0 = reg_wr_in && reg_addr_in == DIV_BASE_ADDR + 16'(OFS_UPDATE) && reg_wdata_in[0] && quiet_r == 4'hF;
  assign srst_wr = reg_wr_in && reg_addr_in == SOFT_RST_ADDR && reg_wdata_in[0] && !soft_reset_busy_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ONE_DIV: assert property (upd0 |=> ($stable(div_num_out[NUM_DIV*NUM_W-1:NUM_W]) &&
    $stable(div_den_out[NUM_DIV*DEN_W-1:DEN_W]))) else $error("other divider moved on update of divider 0");
  AST_NUM_LOAD: assert property (!$stable(div_num_out) |-> ##[0:1] (div_load_out != 5'h00))
    else $error("numerator changed without a load pulse");
  AST_REALIGN: assert property ((div_phase_realign_out & ~(div_load_out & (($past(den_msb) ^ den_msb) |
    ($past(den_msb) ^ $past(den_msb, 2))))) == 5'h00) else $error("realign without denominator top bit change");
  AST_STEP_RD0: assert property (reg_rd_in && reg_addr_in == STEP_REQ_ADDR |=> reg_rdata_out == 8'h00)
    else $error("step request bits read back nonzero");
  AST_SRST_GO: assert property (srst_wr |=> soft_reset_busy_out && !out_clk_enable_out)
    else $error("soft reset did not start");
  AST_SRST_OFF: assert property (soft_reset_busy_out |-> !out_clk_enable_out)
    else $error("clocks enabled during soft reset");
  AST_SRST_LEN: assert property ($rose(soft_reset_busy_out) |-> ##51 (!soft_reset_busy_out && out_clk_enable_out))
    else $error("soft reset length wrong");
  AST_BYP_SET: assert property (reg_wr_in && reg_addr_in == BYPASS_ADDR |->
    ##2 ((div_frac_mode_out & $past(reg_wdata_in[4:0], 2)) == 5'h00)) else $error("bypass bit did not force integer");
  AST_FRAC_LATE: assert property ((div_frac_mode_out & ~$past(div_frac_mode_out)) != 5'h00 |->
    ($past(soft_reset_busy_out) || $past(soft_reset_busy_out, 2) || $past(soft_reset_busy_out, 3)))
    else $error("divider went fractional outside soft reset");
endmodule : fdc_dco_ctrl_chk
`default_nettype wire

// ==== verif/fdc_pin_host.sv ====
// Far-side model that drives the step request pins
`timescale 1ns/1ns
`default_nettype none
module fdc_pin_host
(
  // Clock and pins
  input  wire logic sys_clk_in,
  output logic      inc_out,
  output logic      dec_out
);
  initial begin
    inc_out = 1'b0;
    dec_out = 1'b0;
  end

  // Pins idle low; a pulse of five cycles or fewer is too short to count
  task automatic pulse(input logic dec, input int n);
    @(posedge sys_clk_in);
    #1;
    if (dec) begin
      dec_out = 1'b1;
    end else begin
      inc_out = 1'b1;
    end
    repeat (n) @(posedge sys_clk_in);
    #1;
    inc_out = 1'b0;
    dec_out = 1'b0;
  endtask : pulse
endmodule : fdc_pin_host
`default_nettype wire

// ==== verif/fdc_dco_ctrl_test.sv ====
// Self-checking bench of the fractional divider control block
`timescale 1ns/1ns
`default_nettype none
module fdc_dco_ctrl_test
  import fdc_pkg::*;
;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic [ADDR_W-1:0]        addr = 16'h0000;
  logic [DATA_W-1:0]        wdata = 8'h00;
  logic                     wr_en = 1'b0;
  logic                     rd_en = 1'b0;
  logic [DATA_W-1:0]        rdata;
  logic                     rvalid;
  logic                     inc;
  logic                     dec;
  logic [NUM_DIV*NUM_W-1:0] num;
  logic [NUM_DIV*DEN_W-1:0] den;
  logic [NUM_DIV-1:0]       realign;
  logic [NUM_DIV-1:0]       frac;
  logic                     en;
  logic                     busy;
  int                       errors = 0;
  int                       num_checks = 0;
  int                       cyc = 0;
  longint unsigned          delta, dstep, dhz;
  logic [NUM_W-1:0]         exp_n;
  logic [DATA_W-1:0]        rb;
  logic [DEN_W-1:0]         dv [2] = '{32'h7FFFFFFF, 32'h7FFFFFFE};

  always #10 clk = ~clk;

  fdc_pin_host host (.sys_clk_in(clk), .inc_out(inc), .dec_out(dec));

  fdc_dco_ctrl uut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_en),
    .reg_rd_in(rd_en), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .freq_increment_request_in(inc),
    .freq_decrement_request_in(dec), .div_num_out(num), .div_den_out(den), .div_load_out(),
    .div_phase_realign_out(realign), .div_frac_mode_out(frac), .out_clk_enable_out(en),
    .soft_reset_busy_out(busy));

  // ----------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------
  function automatic logic [NUM_W-1:0] numo(input int i);
    return num[NUM_W*i+:NUM_W];
  endfunction : numo

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int n = 1);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask : wr

  task automatic wr_bytes(input logic [ADDR_W-1:0] a, input logic [47:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      wr(a + ADDR_W'(k), v[8*k+:8]);
    end
  endtask : wr_bytes

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    check(rvalid, 1'b1);
    d = rdata;
  endtask : rd

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(numo(0), NUM_RST);
    check(den[DEN_W*3+:DEN_W], DEN_RST);
    check(frac, 5'h00);
    check(en, 1'b1);
    rd(BYPASS_ADDR, rb);
    check(rb, {3'h0, BYPASS_RST});
    rd(16'h0000, rb);
    check(rb, 8'h00);
    // Cleared bypass bits must wait for a soft reset
    wr(BYPASS_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    check(frac, 5'h00);
    wr(SOFT_RST_ADDR, 8'h01);
    check(busy, 1'b1);
    check(en, 1'b0);
    repeat (60) @(posedge clk);
    check(en, 1'b1);
    check(frac, 5'h1F);
    // 2.5 ppm step down in frequency keeps the ratio above ten; ppm scaled by ten
    delta = (64'h19 * 64'(NUM_RST) + 64'h4C4B4C) / 64'h989699;
    exp_n = NUM_RST + delta[NUM_W-1:0];
    wr_bytes(DIV_BASE_ADDR, {4'h0, exp_n}, 6);
    rd(DIV_BASE_ADDR + 16'h0001, rb);
    check(rb, exp_n[15:8]);
    check(numo(0), NUM_RST);
    wr(DIV_BASE_ADDR + 16'(OFS_UPDATE), 8'h01);
    check(numo(0), exp_n);
    check(numo(1), NUM_RST);
    for (int k = 0; k < 2; k++) begin
      wr_bytes(DIV_BASE_ADDR + DIV_STRIDE + 16'(OFS_DEN), {16'h0000, dv[k]}, 4);
      wr(DIV_BASE_ADDR + DIV_STRIDE + 16'(OFS_UPDATE), 8'h01);
      rb[0] = realign[1];
      @(posedge clk);
      #1;
      check(realign[1] | rb[0], k == 0);
      check(den[DEN_W+:DEN_W], dv[k]);
    end
    // 100 Hz step down on a 100 MHz output, rounded
    dhz = (64'h64 * 64'(NUM_RST) + 64'h2FAF0B2) / 64'h5F5E164;
    wr_bytes(DIV_BASE_ADDR + 16'h0004 * DIV_STRIDE, {4'h0, NUM_RST + dhz[NUM_W-1:0]}, 6);
    wr(UPDATE_ALL_ADDR, 8'h02);
    check(numo(4), NUM_RST + dhz[NUM_W-1:0]);
    // Stepping divider 0 through the request register, by a 1000 ppb step word
    dstep = (64'h3E8 * 64'(exp_n) + 64'h1DCD66F4) / 64'h3B9ACDE8;
    wr_bytes(STEP_BASE_ADDR, {4'h0, dstep[NUM_W-1:0]}, 6);
    wr(STEP_SEL_ADDR, 8'h01);
    wr(STEP_REQ_ADDR, 8'h01);
    check(numo(0), exp_n - dstep[NUM_W-1:0]);
    wr(STEP_REQ_ADDR, 8'h02, 2);
    exp_n = exp_n + dstep[NUM_W-1:0];
    check(numo(0), exp_n);
    wr(STEP_REQ_ADDR, 8'h03);
    check(numo(0), exp_n);
    rd(STEP_REQ_ADDR, rb);
    check(rb, 8'h00);
    rd(DIV_BASE_ADDR, rb);
    check(rb, exp_n[7:0]);
    // Pins: a qualified pulse, a short one, and a long one
    host.pulse(1'b0, 6);
    repeat (12) @(posedge clk);
    check(numo(0), exp_n - dstep[NUM_W-1:0]);
    host.pulse(1'b1, 3);
    repeat (12) @(posedge clk);
    check(numo(0), exp_n - dstep[NUM_W-1:0]);
    host.pulse(1'b1, 20);
    repeat (12) @(posedge clk);
    check(numo(0), exp_n);
    // Setting a bypass bit makes that divider integer without a soft reset
    wr(BYPASS_ADDR, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    check(frac, 5'h0F);
    give_verdict();
  end
endmodule : fdc_dco_ctrl_test

bind fdc_dco_ctrl fdc_dco_ctrl_chk chk_i (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .freq_increment_request_in(freq_increment_request_in), .freq_decrement_request_in(freq_decrement_request_in),
  .div_num_out(div_num_out), .div_den_out(div_den_out), .div_load_out(div_load_out),
  .div_phase_realign_out(div_phase_realign_out), .div_frac_mode_out(div_frac_mode_out),
  .out_clk_enable_out(out_clk_enable_out), .soft_reset_busy_out(soft_reset_busy_out));
`default_nettype wire
